// ==== pkg/pfs_defs.vh ====
// Constants of the program-flow sequencer
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH
`define PFS_OP_JUMP_ALWAYS  8'h16
`define PFS_OP_CALL_SUB     8'h17
`define PFS_OP_RETURN_SUB   8'h18
`define PFS_OP_WAIT         8'h1b
`define PFS_OP_JUMP_COND    8'h15
`define PFS_OP_CLEAR_ERROR  8'h24
`define PFS_JC_TIMEOUT      8'h08
`define PFS_WT_TICKS        8'h00
`define PFS_WT_POSITION     8'h01
`define PFS_WT_HOME_SW      8'h02
`define PFS_WT_END_SW       8'h03
`define PFS_WT_HOMING       8'h04
`define PFS_STACK_DEPTH     4'h8
`define PFS_VAL_FROM_ACC    32'hffffffff
`define PFS_STATUS_OK       8'h64
`define PFS_STATUS_BAD_CMD  8'h02
`define PFS_STATUS_BAD_SUM  8'h01
`define PFS_HOST_ADDR       8'h02
`define PFS_TICK_MS         10
`define PFS_CLK_KHZ         25000
`define PFS_TICK_CYCLES     (`PFS_TICK_MS * `PFS_CLK_KHZ)
`endif

// ==== rtl/pfs_sequencer.v ====
// Program-flow sequencer: jump, call, return, wait and timeout flag
`timescale 1ns/1ns
`include "pfs_defs.vh"
module pfs_sequencer
#(
  parameter TICK_CYCLES = `PFS_TICK_CYCLES
)
(
  clk,
  rst,
  cmd_valid,
  cmd_byte,
  standalone,
  accumulator,
  axis_pos_reached,
  axis_home_switch_hit,
  axis_end_switch_hit,
  axis_homing_done,
  pc_out,
  busy_wait,
  timeout_error_flag,
  stack_depth,
  reply_valid,
  reply_byte,
  step_done
);
  input  wire        clk;
  input  wire        rst;
  input  wire        cmd_valid;
  input  wire [7:0]  cmd_byte;
  input  wire        standalone;
  input  wire [31:0] accumulator;
  input  wire [7:0]  axis_pos_reached;
  input  wire [7:0]  axis_home_switch_hit;
  input  wire [7:0]  axis_end_switch_hit;
  input  wire [7:0]  axis_homing_done;
  output reg  [31:0] pc_out;
  output reg         busy_wait;
  output reg         timeout_error_flag;
  output reg  [3:0]  stack_depth;
  output reg         reply_valid;
  output reg  [7:0]  reply_byte;
  output reg         step_done;

  localparam ST_RX    = 2'd0;
  localparam ST_EXEC  = 2'd1;
  localparam ST_WAIT  = 2'd2;
  localparam ST_REPLY = 2'd3;

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  reg [1:0]  state_r;
  reg [3:0]  rx_cnt_r;
  reg [7:0]  frame_r [0:7];
  reg [7:0]  sum_r;
  reg        sum_ok_r;
  reg [31:0] stack_r [0:7];
  reg [31:0] ticks_left_r;
  reg        timed_r;
  reg [7:0]  status_r;
  reg [31:0] rvalue_r;
  reg [3:0]  tx_cnt_r;
  reg [7:0]  tx_sum_r;
  wire       tick;
  integer    i;

  wire [7:0]  opcode = frame_r[1];
  wire [7:0]  wtype  = frame_r[2];
  wire [2:0]  axis   = frame_r[3][2:0];
  wire [31:0] value  = {frame_r[4], frame_r[5], frame_r[6], frame_r[7]};
  // Accumulator-sourced count
  wire [31:0] count  = (value == `PFS_VAL_FROM_ACC) ? accumulator
                       : value;

  // Selected wait condition
  function cond_met;
    input [7:0] t;
    input [2:0] a;
    begin
      case (t)
        `PFS_WT_POSITION: cond_met = axis_pos_reached[a];
        `PFS_WT_HOME_SW:  cond_met = axis_home_switch_hit[a];
        `PFS_WT_END_SW:   cond_met = axis_end_switch_hit[a];
        `PFS_WT_HOMING:   cond_met = axis_homing_done[a];
        default:          cond_met = 1'b0;
      endcase
    end
  endfunction

  pfs_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .clk  (clk),
    .rst  (rst),
    .tick (tick)
  );

  // Reply byte at position n (n = 0..7; the checksum follows)
  function [7:0] reply_at;
    input [3:0] n;
    begin
      case (n)
        4'h0:    reply_at = `PFS_HOST_ADDR;
        4'h1:    reply_at = frame_r[0];
        4'h2:    reply_at = status_r;
        4'h3:    reply_at = opcode;
        4'h4:    reply_at = rvalue_r[31:24];
        4'h5:    reply_at = rvalue_r[23:16];
        4'h6:    reply_at = rvalue_r[15:8];
        4'h7:    reply_at = rvalue_r[7:0];
        default: reply_at = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r            <= ST_RX;
      rx_cnt_r           <= 4'h0;
      sum_r              <= 8'h00;
      sum_ok_r           <= 1'b0;
      pc_out             <= 32'h00000000;
      busy_wait          <= 1'b0;
      timeout_error_flag <= 1'b0;
      stack_depth        <= 4'h0;
      reply_valid        <= 1'b0;
      reply_byte         <= 8'h00;
      step_done          <= 1'b0;
      ticks_left_r       <= 32'h00000000;
      timed_r            <= 1'b0;
      status_r           <= 8'h00;
      rvalue_r           <= 32'h00000000;
      tx_cnt_r           <= 4'h0;
      tx_sum_r           <= 8'h00;
      for (i = 0; i < 8; i = i + 1)
      begin
        frame_r[i] <= 8'h00;
        stack_r[i] <= 32'h00000000;
      end
    end
    else
    begin
      reply_valid <= 1'b0;
      step_done   <= 1'b0;
      case (state_r)
        ST_RX:
        begin
          if (cmd_valid)
          begin
            if (rx_cnt_r == 4'h8)
            begin
              // Ninth byte is the modulo-256 sum of the first eight
              sum_ok_r <= (cmd_byte == sum_r);
              rx_cnt_r <= 4'h0;
              sum_r    <= 8'h00;
              state_r  <= ST_EXEC;
            end
            else
            begin
              frame_r[rx_cnt_r[2:0]] <= cmd_byte;
              sum_r    <= sum_r + cmd_byte;
              rx_cnt_r <= rx_cnt_r + 4'h1;
            end
          end
        end
        ST_EXEC:
        begin
          status_r <= `PFS_STATUS_OK;
          rvalue_r <= value;
          state_r  <= ST_REPLY;
          if (!sum_ok_r)
            status_r <= `PFS_STATUS_BAD_SUM;
          else if (!standalone)
          begin
            if (opcode == `PFS_OP_JUMP_ALWAYS ||
                opcode == `PFS_OP_CALL_SUB ||
                opcode == `PFS_OP_RETURN_SUB ||
                opcode == `PFS_OP_WAIT)
              status_r <= `PFS_STATUS_BAD_CMD;
          end
          else
          begin
            case (opcode)
              `PFS_OP_JUMP_ALWAYS:
                pc_out <= value;
              `PFS_OP_CALL_SUB:
              begin
                if (stack_depth < `PFS_STACK_DEPTH)
                begin
                  stack_r[stack_depth[2:0]] <= pc_out;
                  stack_depth <= stack_depth + 4'h1;
                  pc_out <= value;
                end
                else
                  pc_out <= pc_out + 32'h00000001;
              end
              `PFS_OP_RETURN_SUB:
              begin
                if (stack_depth != 4'h0)
                begin
                  // Resume after the calling instruction
                  pc_out <= stack_r[stack_depth[2:0] - 3'h1]
                            + 32'h00000001;
                  stack_depth <= stack_depth - 4'h1;
                end
                else
                  pc_out <= pc_out + 32'h00000001;
              end
              `PFS_OP_WAIT:
              begin
                if (wtype > `PFS_WT_HOMING)
                begin
                  status_r <= `PFS_STATUS_BAD_CMD;
                  pc_out   <= pc_out + 32'h00000001;
                end
                else
                begin
                  // Counter stays at this instruction while waiting
                  ticks_left_r <= count;
                  timed_r <= (count != 32'h00000000);
                  busy_wait <= 1'b1;
                  state_r <= ST_WAIT;
                end
              end
              `PFS_OP_JUMP_COND:
              begin
                if (wtype == `PFS_JC_TIMEOUT && timeout_error_flag)
                  pc_out <= value;
                else
                  pc_out <= pc_out + 32'h00000001;
              end
              `PFS_OP_CLEAR_ERROR:
              begin
                timeout_error_flag <= 1'b0;
                pc_out <= pc_out + 32'h00000001;
              end
              default:
                pc_out <= pc_out + 32'h00000001;
            endcase
          end
        end
        ST_WAIT:
        begin
          if (wtype == `PFS_WT_TICKS)
          begin
            if (ticks_left_r == 32'h00000000)
            begin
              busy_wait <= 1'b0;
              pc_out    <= pc_out + 32'h00000001;
              state_r   <= ST_REPLY;
            end
            else if (tick)
              ticks_left_r <= ticks_left_r - 32'h00000001;
          end
          else if (cond_met(wtype, axis))
          begin
            busy_wait <= 1'b0;
            pc_out    <= pc_out + 32'h00000001;
            state_r   <= ST_REPLY;
          end
          else if (timed_r && ticks_left_r == 32'h00000000)
          begin
            timeout_error_flag <= 1'b1;
            busy_wait <= 1'b0;
            pc_out    <= pc_out + 32'h00000001;
            state_r   <= ST_REPLY;
          end
          else if (timed_r && tick)
            ticks_left_r <= ticks_left_r - 32'h00000001;
        end
        ST_REPLY:
        begin
          // Nine bytes, one per cycle, checksum last
          reply_valid <= 1'b1;
          if (tx_cnt_r == 4'h8)
          begin
            reply_byte <= tx_sum_r;
            tx_cnt_r   <= 4'h0;
            tx_sum_r   <= 8'h00;
            step_done  <= 1'b1;
            state_r    <= ST_RX;
          end
          else
          begin
            reply_byte <= reply_at(tx_cnt_r);
            tx_sum_r   <= tx_sum_r + reply_at(tx_cnt_r);
            tx_cnt_r   <= tx_cnt_r + 4'h1;
          end
        end
        default:
          state_r <= ST_RX;
      endcase
    end
  end
endmodule // pfs_sequencer

// ==== rtl/pfs_tick_gen.v ====
// Periodic tick generator for the program-flow sequencer
`timescale 1ns/1ns
`include "pfs_defs.vh"
module pfs_tick_gen
#(
  parameter TICK_CYCLES = `PFS_TICK_CYCLES
)
(
  clk,
  rst,
  tick
);
  input  wire clk;
  input  wire rst;
  output reg  tick;

  reg [31:0] cnt_r;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b0;
    end
    else if (cnt_r >= TICK_CYCLES - 1)
    begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h00000001;
      tick  <= 1'b0;
    end
  end
endmodule // pfs_tick_gen

// ==== tb/pfs_host_model.sv ====
// Command frame source standing in for the host or program memory
`timescale 1ns/1ns
module pfs_host_model
(
  input  wire       clk,
  output reg        cmd_valid,
  output reg  [7:0] cmd_byte
);
  reg     [71:0] fr;
  reg     [7:0]  sum;
  integer        k;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_byte  = 8'h00;
  end
  // Value MSB first; bad spoils the sum to provoke a refusal
  task send(input [7:0] op, ty, mo, input [31:0] v, input bad);
    begin
      fr  = {8'h01, op, ty, mo, v, 8'h00};
      sum = {7'h00, bad};
      for (k = 0; k < 8; k++)
        sum += fr[71 - 8 * k -: 8];
      fr[7:0] = sum;
      for (k = 0; k < 9; k++)
      begin
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_byte  <= fr[71 - 8 * k -: 8];
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      // Released line shows the inverse, not a stale copy
      cmd_byte  <= ~fr[7:0];
    end
  endtask
endmodule // pfs_host_model

// ==== tb/pfs_monitor.sv ====
// Port checker of the program-flow sequencer
`timescale 1ns/1ns
`include "pfs_defs.vh"
module pfs_monitor
(
  input wire        clk,
  input wire        rst,
  input wire        standalone,
  input wire [31:0] pc_out,
  input wire        busy_wait,
  input wire        timeout_error_flag,
  input wire [3:0]  stack_depth,
  input wire        reply_valid,
  input wire [7:0]  reply_byte,
  input wire        step_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_DEPTH_MAX: assert property (stack_depth <= `PFS_STACK_DEPTH)
    else $error("stack too deep");
  AST_DEPTH_STEP: assert property (!$stable(stack_depth) |->
    stack_depth - $past(stack_depth) == 4'h1 ||
    $past(stack_depth) - stack_depth == 4'h1) else $error("stack jump");
  AST_PC_HOLD: assert property (busy_wait && $past(busy_wait) |->
    $stable(pc_out)) else $error("pc moved in wait");
  AST_WAIT_QUIET: assert property (busy_wait |-> !reply_valid)
    else $error("reply during wait");
  AST_REPLY_FRAME: assert property ($rose(reply_valid) |->
    reply_valid[*8] ##1 (reply_valid && step_done) ##1 !reply_valid)
    else $error("reply not nine bytes");
  AST_HOST_FIRST: assert property ($rose(reply_valid) |->
    reply_byte == `PFS_HOST_ADDR) else $error("reply host byte");
  AST_FLAG_SET: assert property ($rose(timeout_error_flag) |->
    $fell(busy_wait)) else $error("flag set outside wait end");
  AST_FLAG_CLEAR: assert property ($fell(timeout_error_flag) |=>
    $rose(reply_valid)) else $error("flag cleared outside command");
  AST_DIRECT: assert property (!standalone |=> $stable(pc_out) &&
    $stable(stack_depth)) else $error("flow acted in direct mode");
endmodule // pfs_monitor

bind pfs_sequencer pfs_monitor i_mon
(
  .clk, .rst, .standalone, .pc_out, .busy_wait, .timeout_error_flag,
  .stack_depth, .reply_valid, .reply_byte, .step_done
);

// ==== tb/program_flow_sequencer_test.sv ====
// Self-checking bench of the program-flow sequencer
`timescale 1ns/1ns
`include "pfs_defs.vh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
  n_mismatch++; $display("BAD %s exp %h got %h", n, e, s); end end
module program_flow_sequencer_test;
  reg         clk = 1'b0;
  reg         rst = 1'b1;
  reg         standalone = 1'b1;
  reg  [31:0] accumulator = 32'h0;
  reg  [7:0]  ax [0:3];
  wire        cmd_valid;
  wire [7:0]  cmd_byte;
  wire [31:0] pc_out;
  wire        busy_wait;
  wire        timeout_error_flag;
  wire [3:0]  stack_depth;
  wire        reply_valid;
  wire [7:0]  reply_byte;
  wire        step_done;
  integer     n_mismatch = 0;
  integer     checks_done = 0;
  integer     nb;
  integer     i;
  integer     j;
  reg  [7:0]  rb [0:8];
  reg  [7:0]  s;
  reg  [31:0] e;
  reg  [31:0] sv [0:7];
  always #20 clk = ~clk;
  pfs_host_model i_host(.clk, .cmd_valid, .cmd_byte);
  pfs_sequencer #(.TICK_CYCLES(10)) i_dut
  (
    .clk, .rst, .cmd_valid, .cmd_byte, .standalone, .accumulator,
    .axis_pos_reached(ax[0]),
    .axis_home_switch_hit(ax[1]),
    .axis_end_switch_hit(ax[2]),
    .axis_homing_done(ax[3]),
    .pc_out, .busy_wait, .timeout_error_flag, .stack_depth,
    .reply_valid, .reply_byte, .step_done
  );
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task xfer(input [7:0] op, ty, mo, input [31:0] v, input bad,
            input [7:0] st);
    integer k;
    begin
      i_host.send(op, ty, mo, v, bad);
      nb = 0;
      for (k = 0; k < 3000 && reply_valid !== 1'b1; k++)
      begin
        @(posedge clk) #1;
        nb += (busy_wait === 1'b1);
      end
      if (reply_valid !== 1'b1)
      begin
        n_mismatch++;
        tally_and_finish;
      end
      s = 8'h00;
      for (k = 0; k < 9; k++)
      begin
        rb[k] = reply_byte;
        if (k < 8) s += reply_byte;
        if (k < 8) @(posedge clk) #1;
      end
      `CHK("target", 8'h01, rb[1])
      `CHK("instr", op, rb[3])
      `CHK("status", st, rb[2])
      `CHK("value", v, {rb[4], rb[5], rb[6], rb[7]})
      `CHK("sum", s, rb[8])
    end
  endtask
  task t_jump;
    begin
      xfer(`PFS_OP_JUMP_ALWAYS, 8'h05, 8'h07, 32'ha, 1'b0, `PFS_STATUS_OK);
      `CHK("pc", 32'ha, pc_out)
      @(posedge clk) standalone <= 1'b0;
      xfer(`PFS_OP_CALL_SUB, 8'h00, 8'h00, 32'h40, 1'b0, `PFS_STATUS_BAD_CMD);
      `CHK("pc", 32'ha, pc_out)
      @(posedge clk) standalone <= 1'b1;
      xfer(`PFS_OP_JUMP_ALWAYS, 8'h00, 8'h00, 32'h55, 1'b1, `PFS_STATUS_BAD_SUM);
      `CHK("pc", 32'ha, pc_out)
      $display("t_jump done");
    end
  endtask
  task t_stack;
    begin
      e = 32'ha;
      for (i = 0; i < 9; i++)
      begin
        xfer(`PFS_OP_CALL_SUB, 8'h00, 8'h00, 32'h100 + i, 1'b0, `PFS_STATUS_OK);
        if (i < 8) sv[i] = e;
        e = (i < 8) ? 32'h100 + i : e + 32'h1;
        `CHK("pc", e, pc_out)
        `CHK("depth", (i < 8) ? i + 1 : 8, stack_depth)
      end
      for (i = 8; i >= 0; i--)
      begin
        xfer(`PFS_OP_RETURN_SUB, 8'h00, 8'h00, 32'h0, 1'b0, `PFS_STATUS_OK);
        e = (i > 0) ? sv[i - 1] + 32'h1 : e + 32'h1;
        `CHK("pc", e, pc_out)
        `CHK("depth", (i > 0) ? i - 1 : 0, stack_depth)
      end
      $display("t_stack done");
    end
  endtask
  task t_wait;
    begin
      xfer(`PFS_OP_WAIT, `PFS_WT_TICKS, 8'h00, 32'h3, 1'b0, `PFS_STATUS_OK);
      `CHK("ticks", 1'b1, nb >= 19 && nb <= 32)
      @(posedge clk) accumulator <= 32'h5;
      xfer(`PFS_OP_WAIT, `PFS_WT_TICKS, 8'h00, `PFS_VAL_FROM_ACC, 1'b0,
           `PFS_STATUS_OK);
      `CHK("acc", 1'b1, nb >= 39 && nb <= 52)
      for (i = 1; i < 5; i++)
      begin
        @(posedge clk)
        for (j = 0; j < 4; j++)
          ax[j] <= (j == i - 1) ? 8'h04 : 8'h08;
        xfer(`PFS_OP_WAIT, i[7:0], 8'h03, 32'h2, 1'b0, `PFS_STATUS_OK);
        `CHK("flag", 1'b1, timeout_error_flag)
        `CHK("tmo", 1'b1, nb >= 9 && nb <= 22)
        xfer(`PFS_OP_JUMP_COND, `PFS_JC_TIMEOUT, 8'h00, 32'h20 + i, 1'b0,
             `PFS_STATUS_OK);
        `CHK("pc", 32'h20 + i, pc_out)
        xfer(`PFS_OP_CLEAR_ERROR, 8'h00, 8'h00, 32'h0, 1'b0, `PFS_STATUS_OK);
        `CHK("flag", 1'b0, timeout_error_flag)
        @(posedge clk)
        for (j = 0; j < 4; j++)
          ax[j] <= (j == i - 1) ? 8'h08 : 8'h00;
        xfer(`PFS_OP_WAIT, i[7:0], 8'h03, 32'h0, 1'b0, `PFS_STATUS_OK);
        `CHK("cond", 1'b0, timeout_error_flag)
        `CHK("pc", 32'h22 + i, pc_out)
      end
      @(posedge clk)
      for (j = 0; j < 4; j++)
        ax[j] <= 8'h00;
      fork
        xfer(`PFS_OP_WAIT, `PFS_WT_POSITION, 8'h03, 32'h0, 1'b0,
             `PFS_STATUS_OK);
        begin
          repeat (200) @(posedge clk);
          `CHK("hold", 1'b1, busy_wait)
          ax[0] <= 8'h08;
        end
      join
      `CHK("flag", 1'b0, timeout_error_flag)
      e = pc_out;
      xfer(`PFS_OP_JUMP_COND, `PFS_JC_TIMEOUT, 8'h00, 32'h77, 1'b0,
           `PFS_STATUS_OK);
      `CHK("jc", e + 32'h1, pc_out)
      xfer(`PFS_OP_WAIT, 8'h05, 8'h00, 32'h0, 1'b0, `PFS_STATUS_BAD_CMD);
      $display("t_wait done");
    end
  endtask
  task t_reset;
    begin
      xfer(`PFS_OP_CALL_SUB, 8'h00, 8'h00, 32'h30, 1'b0, `PFS_STATUS_OK);
      xfer(`PFS_OP_WAIT, `PFS_WT_HOME_SW, 8'h03, 32'h1, 1'b0, `PFS_STATUS_OK);
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      `CHK("depth", 4'h0, stack_depth)
      `CHK("flag", 1'b0, timeout_error_flag)
      $display("t_reset done");
    end
  endtask
  initial
  begin
    for (j = 0; j < 4; j++)
      ax[j] = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_jump;
    t_stack;
    t_wait;
    t_reset;
    tally_and_finish;
  end
endmodule // program_flow_sequencer_test
